// ===== logic/pintc_top.sv
// Purpose: interrupt flags, enables, priorities and request generation
// Assumes: peripheral event inputs are one-cycle pulses, synchronous to clk_i
// Notes:   flag set by hardware always wins over a software clear in the same cycle
`timescale 1ns/100ps

module pintc_top
  import pintc_pkg::*;
#(
  parameter bit PINS28 = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register bus
  input wire pintc_axi_req_s axi_req_i,
  output pintc_axi_resp_s axi_resp_o,
  // peripheral events, first group
  input wire logic par_event_i,
  input wire logic adc_done_i,
  input wire logic rx_full_i,
  input wire logic tx_empty_i,
  input wire logic sser_done_i,
  input wire logic cc1_event_i,
  input wire pintc_cc_mode_e cc1_mode_i,
  input wire logic timer2_match_i,
  input wire logic timer1_ovf_i,
  // peripheral events, second group
  input wire logic clock_fail_i,
  input wire logic [1:0] comparator_out_i,
  input wire logic nvm_write_done_i,
  input wire logic bus_collision_i,
  input wire logic voltage_above_i,
  input wire logic timer3_ovf_i,
  input wire logic cc2_event_i,
  input wire pintc_cc_mode_e cc2_mode_i,
  // core sources
  input wire logic [2:0] ext_pin_i,
  input wire logic [15:0] timer0_count_i,
  input wire logic [3:0] port_upper_i,
  input wire logic port_read_i,
  // core interface
  input wire logic sleep_i,
  input wire logic entry_i,
  input wire logic [20:0] return_pc_i,
  input wire pintc_ctx_s ctx_i,
  output logic irq_high_o,
  output logic irq_low_o,
  output logic wake_o,
  output logic push_o,
  output logic [20:0] push_pc_o,
  output pintc_ctx_s shadow_o
);

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] wd,
                                     input logic hit, input logic [7:0] wm);
    wr8 = hit ? ((old & ~wm) | (wd & wm)) : old;
  endfunction

  function automatic logic edge_hit(input logic prev, input logic cur, input logic pol);
    edge_hit = pol ? (~prev & cur) : (prev & ~cur);
  endfunction

  // an idle or pwm unit raises nothing
  function automatic logic cc_counts(input pintc_cc_mode_e mode);
    cc_counts = (mode == PINTC_CC_CAPTURE) | (mode == PINTC_CC_COMPARE);
  endfunction

  // register state
  logic [7:0] ctrl1_r, ctrl2_r, ctrl3_r, flags1_r, flags2_r;
  logic [7:0] en1_r, en2_r, prio1_r, prio2_r, cfg_r;
  logic [7:0] ctrl1_nxt, ctrl2_nxt, ctrl3_nxt, flags1_nxt, flags2_nxt;
  logic [7:0] en1_nxt, en2_nxt, prio1_nxt, prio2_nxt, cfg_nxt;

  // event history
  logic hist_valid_r;
  logic [2:0] ext_prev_r;
  logic [1:0] cmp_prev_r;
  logic [15:0] t0_prev_r;
  logic [3:0] port_snap_r;

  // bus state
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // context outputs
  logic push_r;
  logic [20:0] push_pc_r;
  pintc_ctx_s shadow_r;

  // variant masks: the parallel port bit vanishes on the small package
  wire [7:0] wm_par = PINS28 ? PINTC_WM_NO_PAR : PINTC_WM_FULL;
  wire [7:0] wm_flags1 = PINTC_WM_FLAGS1 & wm_par;
  wire [7:0] rst_prio1 = PINTC_RST_PRIO & wm_par;
  wire [7:0] rst_prio2 = PINTC_RST_PRIO & PINTC_WM_SET2;

  // write channel
  wire do_write = aw_held_r & w_held_r & ~bvalid_r;
  // a write without the low byte lane leaves every register alone
  wire wr_lane = wstrb_r[0];
  wire [7:0] wd = wdata_r[7:0];
  wire wr_ctrl1 = do_write & wr_lane & (awaddr_r == PINTC_OFS_CTRL1);
  wire wr_ctrl2 = do_write & wr_lane & (awaddr_r == PINTC_OFS_CTRL2);
  wire wr_ctrl3 = do_write & wr_lane & (awaddr_r == PINTC_OFS_CTRL3);
  wire wr_flags1 = do_write & wr_lane & (awaddr_r == PINTC_OFS_FLAGS1);
  wire wr_flags2 = do_write & wr_lane & (awaddr_r == PINTC_OFS_FLAGS2);
  wire wr_en1 = do_write & wr_lane & (awaddr_r == PINTC_OFS_EN1);
  wire wr_en2 = do_write & wr_lane & (awaddr_r == PINTC_OFS_EN2);
  wire wr_prio1 = do_write & wr_lane & (awaddr_r == PINTC_OFS_PRIO1);
  wire wr_prio2 = do_write & wr_lane & (awaddr_r == PINTC_OFS_PRIO2);
  wire wr_cfg = do_write & wr_lane & (awaddr_r == PINTC_OFS_CFG);
  wire wr_mapped = (awaddr_r == PINTC_OFS_CTRL1) | (awaddr_r == PINTC_OFS_CTRL2) |
                   (awaddr_r == PINTC_OFS_CTRL3) | (awaddr_r == PINTC_OFS_FLAGS1) |
                   (awaddr_r == PINTC_OFS_FLAGS2) | (awaddr_r == PINTC_OFS_EN1) |
                   (awaddr_r == PINTC_OFS_EN2) | (awaddr_r == PINTC_OFS_PRIO1) |
                   (awaddr_r == PINTC_OFS_PRIO2) | (awaddr_r == PINTC_OFS_CFG);

  // read decode
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (axi_req_i.araddr)
      PINTC_OFS_CTRL1: rd_byte = ctrl1_r;
      PINTC_OFS_CTRL2: rd_byte = ctrl2_r;
      PINTC_OFS_CTRL3: rd_byte = ctrl3_r;
      PINTC_OFS_FLAGS1: rd_byte = flags1_r;
      PINTC_OFS_FLAGS2: rd_byte = flags2_r;
      PINTC_OFS_EN1: rd_byte = en1_r;
      PINTC_OFS_EN2: rd_byte = en2_r;
      PINTC_OFS_PRIO1: rd_byte = prio1_r;
      PINTC_OFS_PRIO2: rd_byte = prio2_r;
      PINTC_OFS_CFG: rd_byte = cfg_r;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // event detection
  wire priority_scheme_enable = cfg_r[PINTC_B_PRIORITY_SCHEME_ENABLE];
  wire vdir = cfg_r[PINTC_B_VDIR];
  wire [2:0] ext_pol = {ctrl2_r[PINTC_B_X2_POL], ctrl2_r[PINTC_B_X1_POL],
                        ctrl2_r[PINTC_B_X0_POL]};
  // first sample after reset only seeds the history, so no false edge
  wire [2:0] ext_edge = {3{hist_valid_r}} &
                        {edge_hit(ext_prev_r[2], ext_pin_i[2], ext_pol[2]),
                         edge_hit(ext_prev_r[1], ext_pin_i[1], ext_pol[1]),
                         edge_hit(ext_prev_r[0], ext_pin_i[0], ext_pol[0])};
  wire t0_roll8 = (t0_prev_r[7:0] == PINTC_T0_MAX8) &
                  (timer0_count_i[7:0] == ~PINTC_T0_MAX8);
  wire t0_roll16 = (t0_prev_r == PINTC_T0_MAX16) &
                   (timer0_count_i == ~PINTC_T0_MAX16);
  wire t0_ovf = cfg_r[PINTC_B_T0_16] ? t0_roll16 : t0_roll8;
  // mismatch keeps setting until a port read refreshes the snapshot
  wire port_change = hist_valid_r & (|(port_upper_i ^ port_snap_r));
  wire cmp_change = hist_valid_r & (|(comparator_out_i ^ cmp_prev_r));
  wire v_cond = vdir ? voltage_above_i : ~voltage_above_i;
  wire cc1_set = cc1_event_i & cc_counts(cc1_mode_i);
  wire cc2_set = cc2_event_i & cc_counts(cc2_mode_i);

  // set vectors, independent of every enable
  wire [7:0] set_ctrl1 = {5'h00, t0_ovf, ext_edge[0], port_change};
  wire [7:0] set_ctrl3 = {6'h00, ext_edge[2], ext_edge[1]};
  wire [7:0] set_flags1 = {par_event_i, adc_done_i, 2'h0, sser_done_i, cc1_set,
                           timer2_match_i, timer1_ovf_i} & wm_flags1;
  wire [7:0] set_flags2 = {clock_fail_i, cmp_change, 1'b0, nvm_write_done_i,
                           bus_collision_i, v_cond, timer3_ovf_i,
                           cc2_set};

  // next values: set wins over a software clear
  assign ctrl1_nxt = wr8(ctrl1_r, wd, wr_ctrl1, PINTC_WM_CTRL1) | set_ctrl1;
  assign ctrl2_nxt = wr8(ctrl2_r, wd, wr_ctrl2, PINTC_WM_CTRL2);
  assign ctrl3_nxt = wr8(ctrl3_r, wd, wr_ctrl3, PINTC_WM_CTRL3) | set_ctrl3;
  // receive and transmit bits mirror the serial buffer state, not software
  wire [7:0] ro_flags1 = (8'h01 << PINTC_B_RX) | (8'h01 << PINTC_B_TX);
  assign flags1_nxt = (wr8(flags1_r, wd, wr_flags1, wm_flags1) & ~ro_flags1) | set_flags1 |
                      {2'h0, rx_full_i, tx_empty_i, 4'h0};
  assign flags2_nxt = wr8(flags2_r, wd, wr_flags2, PINTC_WM_SET2) | set_flags2;
  assign en1_nxt = wr8(en1_r, wd, wr_en1, wm_par);
  assign en2_nxt = wr8(en2_r, wd, wr_en2, PINTC_WM_SET2);
  assign prio1_nxt = wr8(prio1_r, wd, wr_prio1, wm_par);
  assign prio2_nxt = wr8(prio2_r, wd, wr_prio2, PINTC_WM_SET2);
  assign cfg_nxt = wr8(cfg_r, wd, wr_cfg, PINTC_WM_CFG);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl1_r <= PINTC_RST_CTRL1;
      ctrl2_r <= PINTC_RST_CTRL2;
      ctrl3_r <= PINTC_RST_CTRL3;
      flags1_r <= PINTC_RST_ZERO;
      flags2_r <= PINTC_RST_ZERO;
      en1_r <= PINTC_RST_ZERO;
      en2_r <= PINTC_RST_ZERO;
      prio1_r <= rst_prio1;
      prio2_r <= rst_prio2;
      cfg_r <= PINTC_RST_ZERO;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      ctrl3_r <= ctrl3_nxt;
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
      en1_r <= en1_nxt;
      en2_r <= en2_nxt;
      prio1_r <= prio1_nxt;
      prio2_r <= prio2_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // history registers load from ports after reset, so no port value enters reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hist_valid_r <= 1'b0;
      ext_prev_r <= 3'h0;
      cmp_prev_r <= 2'h0;
      t0_prev_r <= 16'h0000;
      port_snap_r <= 4'h0;
    end else begin
      hist_valid_r <= 1'b1;
      ext_prev_r <= ext_pin_i;
      cmp_prev_r <= comparator_out_i;
      t0_prev_r <= timer0_count_i;
      if (port_read_i | ~hist_valid_r) begin
        port_snap_r <= port_upper_i;
      end
    end
  end

  // request generation
  wire [7:0] act1 = flags1_r & en1_r;
  wire [7:0] act2 = flags2_r & en2_r;
  wire t0_act = ctrl1_r[PINTC_B_T0_FLAG] & ctrl1_r[PINTC_B_T0_EN];
  wire x0_act = ctrl1_r[PINTC_B_X0_FLAG] & ctrl1_r[PINTC_B_X0_EN];
  wire x1_act = ctrl3_r[PINTC_B_X1_FLAG] & ctrl3_r[PINTC_B_X1_EN];
  wire x2_act = ctrl3_r[PINTC_B_X2_FLAG] & ctrl3_r[PINTC_B_X2_EN];
  wire pc_act = ctrl1_r[PINTC_B_PC_FLAG] & ctrl1_r[PINTC_B_PC_EN];
  wire core_hi = x0_act | (x1_act & ctrl3_r[PINTC_B_X1_PRIO]) |
                 (x2_act & ctrl3_r[PINTC_B_X2_PRIO]) |
                 (t0_act & ctrl2_r[PINTC_B_T0_PRIO]) |
                 (pc_act & ctrl2_r[PINTC_B_PC_PRIO]);
  wire core_lo = (x1_act & ~ctrl3_r[PINTC_B_X1_PRIO]) |
                 (x2_act & ~ctrl3_r[PINTC_B_X2_PRIO]) |
                 (t0_act & ~ctrl2_r[PINTC_B_T0_PRIO]) |
                 (pc_act & ~ctrl2_r[PINTC_B_PC_PRIO]);
  wire per_hi = |(act1 & prio1_r) | |(act2 & prio2_r);
  wire per_lo = |(act1 & ~prio1_r) | |(act2 & ~prio2_r);
  wire per_any = |act1 | |act2;
  wire ge = ctrl1_r[PINTC_B_GE];
  wire pge = ctrl1_r[PINTC_B_PGE];
  wire flat_req = ge & (x0_act | x1_act | x2_act | t0_act | pc_act |
                        (pge & per_any));
  wire hi_req = priority_scheme_enable ? (ge & (core_hi | per_hi)) : flat_req;
  wire lo_req = priority_scheme_enable & pge & (core_lo | per_lo);

  // low is masked while high is pending, so the core never sees both
  assign irq_high_o = hi_req;
  assign irq_low_o = lo_req & ~hi_req;
  // wake needs only the pin enable; vectoring then follows the request outputs
  assign wake_o = sleep_i & (x0_act | x1_act | x2_act);

  // context capture on interrupt entry
  // shadow holds until the next entry, ready for a fast return
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      push_r <= 1'b0;
      push_pc_r <= 21'h000000;
      shadow_r <= '0;
    end else begin
      push_r <= entry_i;
      if (entry_i) begin
        push_pc_r <= return_pc_i;
        shadow_r <= ctx_i;
      end
    end
  end
  assign push_o = push_r;
  assign push_pc_o = push_pc_r;
  assign shadow_o = shadow_r;

  // bus slave: address and data taken in either order, one at a time
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end else if (axi_req_i.awvalid & ~aw_held_r & ~bvalid_r) begin
      aw_held_r <= 1'b1;
      awaddr_r <= axi_req_i.awaddr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end else if (axi_req_i.wvalid & ~w_held_r & ~bvalid_r) begin
      w_held_r <= 1'b1;
      wdata_r <= axi_req_i.wdata;
      wstrb_r <= axi_req_i.wstrb;
    end
  end

  // an unmapped write still completes, but answers with an error
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= PINTC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? PINTC_RESP_OKAY : PINTC_RESP_SLVERR;
    end else if (bvalid_r & axi_req_i.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read answers one cycle after the address; data stands until taken
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= PINTC_RESP_OKAY;
    end else if (axi_req_i.arvalid & ~rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? PINTC_RESP_OKAY : PINTC_RESP_SLVERR;
    end else if (rvalid_r & axi_req_i.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign axi_resp_o.awready = ~aw_held_r & ~bvalid_r;
  assign axi_resp_o.wready = ~w_held_r & ~bvalid_r;
  assign axi_resp_o.bvalid = bvalid_r;
  assign axi_resp_o.bresp = bresp_r;
  assign axi_resp_o.arready = ~rvalid_r;
  assign axi_resp_o.rvalid = rvalid_r;
  assign axi_resp_o.rdata = rdata_r;
  assign axi_resp_o.rresp = rresp_r;

endmodule

// ===== shared/pintc_pkg.sv
// Purpose: constants and carrier types for the peripheral interrupt controller
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   registers hold 8 significant bits; upper bits read as zero
package pintc_pkg;

  // register byte offsets
  localparam logic [7:0] PINTC_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] PINTC_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] PINTC_OFS_CTRL3 = 8'h08;
  localparam logic [7:0] PINTC_OFS_FLAGS1 = 8'h0c;
  localparam logic [7:0] PINTC_OFS_FLAGS2 = 8'h10;
  localparam logic [7:0] PINTC_OFS_EN1 = 8'h14;
  localparam logic [7:0] PINTC_OFS_EN2 = 8'h18;
  localparam logic [7:0] PINTC_OFS_PRIO1 = 8'h1c;
  localparam logic [7:0] PINTC_OFS_PRIO2 = 8'h20;
  localparam logic [7:0] PINTC_OFS_CFG = 8'h24;

  // reset values
  localparam logic [7:0] PINTC_RST_CTRL1 = 8'h00;
  localparam logic [7:0] PINTC_RST_CTRL2 = 8'h75;
  localparam logic [7:0] PINTC_RST_CTRL3 = 8'hc0;
  localparam logic [7:0] PINTC_RST_ZERO = 8'h00;
  localparam logic [7:0] PINTC_RST_PRIO = 8'hff;

  // writable masks
  localparam logic [7:0] PINTC_WM_CTRL1 = 8'hff;
  localparam logic [7:0] PINTC_WM_CTRL2 = 8'h75;
  localparam logic [7:0] PINTC_WM_CTRL3 = 8'hdb;
  localparam logic [7:0] PINTC_WM_FLAGS1 = 8'hcf;
  localparam logic [7:0] PINTC_WM_SET2 = 8'hdf;
  localparam logic [7:0] PINTC_WM_CFG = 8'h07;
  localparam logic [7:0] PINTC_WM_FULL = 8'hff;
  localparam logic [7:0] PINTC_WM_NO_PAR = 8'h7f;

  // control register 1 fields
  localparam int PINTC_B_GE = 7;
  localparam int PINTC_B_PGE = 6;
  localparam int PINTC_B_T0_EN = 5;
  localparam int PINTC_B_X0_EN = 4;
  localparam int PINTC_B_PC_EN = 3;
  localparam int PINTC_B_T0_FLAG = 2;
  localparam int PINTC_B_X0_FLAG = 1;
  localparam int PINTC_B_PC_FLAG = 0;
  // control register 2 fields
  localparam int PINTC_B_X0_POL = 6;
  localparam int PINTC_B_X1_POL = 5;
  localparam int PINTC_B_X2_POL = 4;
  localparam int PINTC_B_T0_PRIO = 2;
  localparam int PINTC_B_PC_PRIO = 0;
  // control register 3 fields
  localparam int PINTC_B_X2_PRIO = 7;
  localparam int PINTC_B_X1_PRIO = 6;
  localparam int PINTC_B_X2_EN = 4;
  localparam int PINTC_B_X1_EN = 3;
  localparam int PINTC_B_X2_FLAG = 1;
  localparam int PINTC_B_X1_FLAG = 0;
  // peripheral register 1 fields
  localparam int PINTC_B_PAR = 7;
  localparam int PINTC_B_RX = 5;
  localparam int PINTC_B_TX = 4;
  localparam int PINTC_B_CC1 = 2;
  // peripheral register 2 fields
  localparam int PINTC_B_OSCF = 7;
  localparam int PINTC_B_CMP = 6;
  localparam int PINTC_B_UNUSED2 = 5;
  localparam int PINTC_B_NVM = 4;
  localparam int PINTC_B_BCOL = 3;
  localparam int PINTC_B_VDET = 2;
  localparam int PINTC_B_T3 = 1;
  localparam int PINTC_B_CC2 = 0;
  // configuration register fields
  localparam int PINTC_B_PRIORITY_SCHEME_ENABLE = 0;
  localparam int PINTC_B_T0_16 = 1;
  localparam int PINTC_B_VDIR = 2;

  localparam logic [7:0] PINTC_T0_MAX8 = 8'hff;
  localparam logic [15:0] PINTC_T0_MAX16 = 16'hffff;

  localparam logic [1:0] PINTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PINTC_RESP_SLVERR = 2'h2;

  // capture/compare unit operating mode
  typedef enum logic [1:0] {
    PINTC_CC_OFF,
    PINTC_CC_CAPTURE,
    PINTC_CC_COMPARE,
    PINTC_CC_PWM
  } pintc_cc_mode_e;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } pintc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pintc_axi_resp_s;

  typedef struct packed {
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
  } pintc_ctx_s;

endpackage

// ===== verification/pintc_top_props.sv
// Purpose: port-level checks for the interrupt controller
// Assumes: one clock domain, synchronous active-low reset
// Notes: a write answers two edges after address and data, a read one edge
`timescale 1ns/100ps

module pintc_top_props
  import pintc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register bus
  input wire pintc_axi_req_s axi_req_i,
  input wire pintc_axi_resp_s axi_resp_o,
  // core side
  input wire logic sleep_i,
  input wire logic entry_i,
  input wire logic [20:0] return_pc_i,
  input wire pintc_ctx_s ctx_i,
  input wire logic irq_high_o,
  input wire logic irq_low_o,
  input wire logic wake_o,
  input wire logic push_o,
  input wire logic [20:0] push_pc_o,
  input wire pintc_ctx_s shadow_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_entry;
    entry_i ##1 push_o;
  endsequence
  property p_push; entry_i |=> push_o; endproperty
  property p_pc; s_entry |-> push_pc_o == $past(return_pc_i); endproperty
  property p_ctx; s_entry |-> shadow_o == $past(ctx_i); endproperty
  property p_prio; irq_low_o |-> !irq_high_o; endproperty
  property p_wake; wake_o |-> sleep_i; endproperty
  // reset must drop every request, whatever was pending
  property p_rst;
    disable iff (1'b0) !rstn_i |=> !irq_high_o && !irq_low_o && !push_o;
  endproperty
  property p_wlat;
    axi_req_i.awvalid && axi_resp_o.awready && axi_req_i.wvalid && axi_resp_o.wready
      |-> ##2 axi_resp_o.bvalid;
  endproperty
  property p_bdrop; axi_resp_o.bvalid && axi_req_i.bready |=> !axi_resp_o.bvalid; endproperty
  property p_rlat; axi_req_i.arvalid && axi_resp_o.arready |=> axi_resp_o.rvalid; endproperty
  a_push: assert property (p_push) else $error("no push after entry");
  a_pc: assert property (p_pc) else $error("pushed address wrong");
  a_ctx: assert property (p_ctx) else $error("shadow copy wrong");
  a_prio: assert property (p_prio) else $error("low request beside high");
  a_wake: assert property (p_wake) else $error("wake while awake");
  a_rst: assert property (p_rst) else $error("request after reset");
  a_wlat: assert property (p_wlat) else $error("write answer late");
  a_bdrop: assert property (p_bdrop) else $error("write answer stuck");
  a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule

bind pintc_top pintc_top_props u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(axi_req_i), .axi_resp_o(axi_resp_o),
  .sleep_i(sleep_i), .entry_i(entry_i), .return_pc_i(return_pc_i), .ctx_i(ctx_i),
  .irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .wake_o(wake_o), .push_o(push_o),
  .push_pc_o(push_pc_o), .shadow_o(shadow_o)
);

// ===== verification/pintc_periph_model.sv
// Purpose: peripheral side, turns fire requests into event pulses
// Assumes: fire bits follow the second flag register layout
// Notes: events land one cycle after the request, as a registered source would
`timescale 1ns/100ps

module pintc_periph_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // requests and events
  input wire logic [7:0] fire_i,
  output logic [7:0] ev_o,
  output logic [1:0] cmp_o
);
  always_ff @(posedge clk_i) begin
    ev_o <= fire_i;
    cmp_o <= rstn_i ? cmp_o ^ {1'b0, fire_i[6]} : 2'h0;
  end
endmodule

// ===== verification/pintc_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: register model m indexed by byte offset over four
// Notes: voltage input idles high so only a dip counts with direction zero
`timescale 1ns/100ps

module pintc_tb;
  import pintc_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  pintc_axi_req_s req = '{wstrb: 4'hf, default: '0};
  pintc_axi_resp_s resp;
  logic [7:0] fire = 8'h00;
  logic [7:0] f1 = 8'h00;
  logic [7:0] ev;
  logic [1:0] cmp;
  pintc_cc_mode_e cc_mode = PINTC_CC_CAPTURE;
  logic [2:0] pins = 3'h0;
  logic [3:0] port = 4'h0;
  logic prd = 1'b0;
  logic [15:0] t0 = 16'h0000;
  logic sleep = 1'b0;
  logic entry = 1'b0;
  logic [20:0] pc = 21'h0;
  pintc_ctx_s ctx = '0;
  logic irq_high, irq_low, wake, push;
  logic [20:0] push_pc;
  pintc_ctx_s shadow;
  int bad_count = 0;
  int check_count = 0;
  int seed = 42;
  int b, md;
  logic e;
  int rv[10] = '{0, 'h75, 'hc0, 0, 0, 0, 0, 'hff, 'hdf, 0};
  int wm[10] = '{'hff, 'h75, 'hdb, 'hcf, 'hdf, 'hff, 'hdf, 'hff, 'hdf, 'h07};
  int tb[6] = '{'h0800, 'h0c02, 'h9012, 'h8de1, 'h0401, 'h0800};
  int tw[3] = '{'h00ff0000, 'h00ff0100, 'hffff0000};
  int m[10];

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  pintc_periph_model u_periph (.clk_i(clk_i), .rstn_i(rstn_i), .fire_i(fire), .ev_o(ev),
    .cmp_o(cmp));

  pintc_top uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(req), .axi_resp_o(resp),
    .par_event_i(f1[7]), .adc_done_i(f1[6]), .rx_full_i(f1[5]), .tx_empty_i(f1[4]),
    .sser_done_i(f1[3]), .cc1_event_i(f1[2]), .cc1_mode_i(cc_mode),
    .timer2_match_i(f1[1]), .timer1_ovf_i(f1[0]), .clock_fail_i(ev[7]),
    .comparator_out_i(cmp), .nvm_write_done_i(ev[4]), .bus_collision_i(ev[3]),
    .voltage_above_i(!ev[2]), .timer3_ovf_i(ev[1]), .cc2_event_i(ev[0]),
    .cc2_mode_i(cc_mode), .ext_pin_i(pins), .timer0_count_i(t0), .port_upper_i(port),
    .port_read_i(prd), .sleep_i(sleep), .entry_i(entry), .return_pc_i(pc), .ctx_i(ctx),
    .irq_high_o(irq_high), .irq_low_o(irq_low), .wake_o(wake), .push_o(push),
    .push_pc_o(push_pc), .shadow_o(shadow)
  );

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access at a time; ready is looked at before the edge that takes it
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic [1:0] r);
    bit pa;
    bit pw;
    @(posedge clk_i);
    pa = 1'b1;
    pw = w;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= {24'h0, d};
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    while (pa || pw) begin
      @(negedge clk_i);
      pa = pa && !(w ? resp.awready : resp.arready);
      pw = pw && !resp.wready;
      @(posedge clk_i);
      req.awvalid <= w && pa;
      req.arvalid <= !w && pa;
      req.wvalid <= pw;
    end
    do @(negedge clk_i); while (!(w ? resp.bvalid : resp.rvalid));
    q = resp.rdata[7:0];
    r = w ? resp.bresp : resp.rresp;
    @(posedge clk_i);
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask

  task automatic rchk(input int i);
    logic [7:0] q;
    logic [1:0] r;
    bus(1'b0, 8'(i * 4), 8'h00, q, r);
    cmp32(q, m[i]);
    cmp32(r, PINTC_RESP_OKAY);
  endtask

  task automatic wrm(input int i, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] r;
    bus(1'b1, 8'(i * 4), d, q, r);
    cmp32(r, PINTC_RESP_OKAY);
    m[i] = d & wm[i];
  endtask

  task automatic pulse(input int g, input int n);
    if (g == 1) fire <= 8'(1 << n);
    else f1 <= 8'(1 << n);
    @(posedge clk_i);
    fire <= 8'h00;
    f1 <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // whole run takes a few hundred cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    logic [7:0] q;
    logic [1:0] r;
    m = rv;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(i);
    bus(1'b0, 8'h28, 8'h00, q, r);
    cmp32({q, r}, {8'h00, PINTC_RESP_SLVERR});
    bus(1'b1, 8'h28, 8'hff, q, r);
    cmp32(r, PINTC_RESP_SLVERR);
    for (int i = 0; i < 9; i++) begin
      wrm(i, 8'hff);
      rchk(i);
      wrm(i, 8'(rv[i]));
    end
    $display("test registers finished");
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 12; k++) begin
        b = k > 7 ? 2 - 2 * g : k;
        if (b == 5 || (g == 0 && b == 4)) continue;
        md = k > 7 ? k - 8 : 1;
        cc_mode <= pintc_cc_mode_e'(md);
        pulse(g, b);
        if (k < 8 || md == 1 || md == 2) m[3 + g] = 1 << b;
        rchk(3 + g);
        wrm(3 + g, 8'h00);
      end
    end
    cc_mode <= PINTC_CC_CAPTURE;
    $display("test flags finished");
    wrm(6, 8'h01);
    pulse(1, 0);
    m[4] = 1;
    for (int i = 0; i < 6; i++) begin
      wrm(tb[i] >> 12, 8'(tb[i] >> 4));
      @(negedge clk_i);
      cmp32({irq_high, irq_low}, tb[i] & 3);
    end
    wrm(9, 8'h00);
    wrm(6, 8'h00);
    wrm(4, 8'h00);
    wrm(8, 8'hdf);
    $display("test requests finished");
    sleep <= 1'b1;
    wrm(0, 8'h10);
    wrm(9, 8'h01);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wrm(1, 8'h35);
      pins[0] <= !pins[0];
      repeat (3) @(posedge clk_i);
      e = (i == 0 || i == 3);
      m[0] = m[0] | (e << 1);
      rchk(0);
      @(negedge clk_i);
      cmp32({wake, irq_high, irq_low}, {e, e && i > 0, 1'b0});
      wrm(0, 8'h90);
    end
    sleep <= 1'b0;
    wrm(0, 8'h00);
    wrm(1, 8'h75);
    wrm(9, 8'h00);
    $display("test pins finished");
    for (int i = 0; i < 3; i++) begin
      if (i == 1) wrm(9, 8'h02);
      t0 <= 16'(tw[i] >> 16);
      @(posedge clk_i);
      t0 <= 16'(tw[i]);
      repeat (3) @(posedge clk_i);
      m[0] = m[0] | ((i != 1) << 2);
      rchk(0);
      wrm(0, 8'h00);
    end
    wrm(9, 8'h00);
    $display("test timer finished");
    wrm(9, 8'h01);
    wrm(0, 8'hc0);
    wrm(2, 8'h50);
    pins[2:1] <= 2'h3;
    repeat (3) @(posedge clk_i);
    m[2] = 8'h53;
    rchk(2);
    @(negedge clk_i);
    cmp32({irq_high, irq_low}, 2'h1);
    wrm(2, 8'h49);
    @(negedge clk_i);
    cmp32({irq_high, irq_low}, 2'h2);
    wrm(2, 8'hc0);
    wrm(9, 8'h00);
    wrm(0, 8'h00);
    port <= 4'h5;
    repeat (3) @(posedge clk_i);
    m[0] = 8'h01;
    rchk(0);
    wrm(0, 8'h88);
    @(negedge clk_i);
    cmp32({irq_high, irq_low}, 2'h2);
    m[0] = 8'h89;
    rchk(0);
    prd <= 1'b1;
    @(posedge clk_i);
    prd <= 1'b0;
    wrm(0, 8'h00);
    rchk(0);
    $display("test sources finished");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      pc <= 21'($random(seed));
      ctx <= 24'($random(seed));
      entry <= 1'b1;
      @(posedge clk_i);
      entry <= 1'b0;
      @(negedge clk_i);
      cmp32({push, push_pc}, {1'b1, pc});
      cmp32(shadow, ctx);
    end
    $display("test entry finished");
    report_and_stop();
  end
endmodule
